// ===== design/port2_phy_pkg.sv
package port2_phy_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] PORT2_PHY_CONTROL_OFS = 8'h96;
   localparam logic [ADDR_W-1:0] PORT2_PHY_STATUS_OFS = 8'h98;
   localparam logic [15:0] PORT2_PHY_CONTROL_RST = 16'h00FF;
   localparam logic STS_ALGO_RST = 1'b1;
   localparam logic [4:0] PARTNER_RST = 5'h00;
   localparam logic [15:0] RDATA_NONE = 16'h0000;

   // ---------------------------------------------------------------
   // control register fields
   // ---------------------------------------------------------------
   localparam int CTL_RSVD15 = 15;
   localparam int CTL_TX_DIS = 14;
   localparam int CTL_AN_RESTART = 13;
   localparam int CTL_RSVD12 = 12;
   localparam int CTL_POWER_DOWN = 11;
   localparam int CTL_MDIX_DIS = 10;
   localparam int CTL_FORCE_MDIX = 9;
   localparam int CTL_FAR_LOOP = 8;
   localparam int CTL_AN_EN = 7;
   localparam int CTL_SPEED = 6;
   localparam int CTL_DUPLEX = 5;
   localparam int CTL_ADV_LSB = 0;
   localparam int ADV_W = 5;

   // ---------------------------------------------------------------
   // status register fields
   // ---------------------------------------------------------------
   localparam int STS_ALGO = 15;
   localparam int STS_POL_REV = 13;
   localparam int STS_TX_FC = 12;
   localparam int STS_RX_FC = 11;
   localparam int STS_SPEED = 10;
   localparam int STS_DUPLEX = 9;
   localparam int STS_MDIX = 7;
   localparam int STS_AN_DONE = 6;
   localparam int STS_LINK = 5;
   localparam int STS_PARTNER_LSB = 0;

   // ---------------------------------------------------------------
   // standard register alias fields
   // ---------------------------------------------------------------
   localparam int BC_FAR_LOOP = 14;
   localparam int BC_SPEED = 13;
   localparam int BC_AN_EN = 12;
   localparam int BC_POWER_DOWN = 11;
   localparam int BC_AN_RESTART = 9;
   localparam int BC_DUPLEX = 8;
   localparam int BC_ALGO = 5;
   localparam int BC_FORCE_MDIX = 4;
   localparam int BC_MDIX_DIS = 3;
   localparam int BC_RSVD = 2;
   localparam int BC_TX_DIS = 1;
   localparam int BS_AN_DONE = 5;
   localparam int BS_LINK = 2;
   localparam int AB_PAUSE = 10;
   localparam int AB_TECH_LSB = 5;
   localparam int SP_POL_REV = 5;
   localparam int SP_MDIX = 4;

endpackage : port2_phy_pkg

// ===== design/phy_mode_resolve.sv
`timescale 1ns/1ps
module phy_mode_resolve
   import port2_phy_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   // control fields
   input wire logic an_en,
   input wire logic force_speed100,
   input wire logic force_full,
   input wire logic mdix_dis,
   input wire logic mdix_force_req,
   // negotiation result from the phy
   input wire logic an_done,
   input wire logic an_failed,
   input wire logic an_speed100,
   input wire logic an_full,
   // resolved mode
   output logic speed100_q,
   output logic full_duplex_q,
   output logic auto_mdix_en_q,
   output logic force_mdix_q
);

   // ---------------------------------------------------------------
   // speed and duplex
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         speed100_q <= 1'b0;
         full_duplex_q <= 1'b0;
      end else if (ce) begin
         if (!an_en) begin
            speed100_q <= force_speed100;
            full_duplex_q <= force_full;
         end else if (an_done) begin
            speed100_q <= an_speed100;
            full_duplex_q <= an_full;
         end else if (an_failed) begin
            // parallel detect still gives speed, duplex falls back
            speed100_q <= an_speed100;
            full_duplex_q <= force_full;
         end
      end
   end

   // ---------------------------------------------------------------
   // crossover
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         auto_mdix_en_q <= 1'b1;
         force_mdix_q <= 1'b0;
      end else if (ce) begin
         auto_mdix_en_q <= !mdix_dis;
         force_mdix_q <= mdix_dis && mdix_force_req;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   chk_forced_mode: assert property (
      ce && !an_en |=> speed100_q == $past(force_speed100))
      else $error("forced speed not applied");

   chk_fail_duplex: assert property (
      ce && an_en && !an_done && an_failed
         |=> full_duplex_q == $past(force_full))
      else $error("duplex fallback wrong after failed negotiation");

   chk_mdix_force: assert property (
      ce && !(mdix_dis && mdix_force_req) |=> !force_mdix_q)
      else $error("crossover forced without both controls");

endmodule : phy_mode_resolve

// ===== design/port2_phy_ctrl_status_regs.sv
// Behaviour
// - control bit 14 set disables the port transmitter; resets to zero
// - writing one to bit 13 restarts negotiation; bit then clears itself
// - bit 11 powers the phy down; register contents stay untouched
// - bit 10 set disables automatic crossover; zero keeps it enabled
// - bit 9 forces MDI-X only while automatic crossover is disabled
// - bit 8 loops first-port traffic at this phy's PMD/PMA
// - bit 7 enables negotiation, resets one; off means bits 6:5 decide
// - with negotiation off, bit 6 picks 100 (one) or 10 Mbit
// - bit 5 picks duplex when forced or when negotiation fails
// - bits 4:0 advertise pause, 100F, 100H, 10F, 10H; all reset one
// - status bit 15 writable, resets one; selects crossover algorithm
// - status 13 reports reversed polarity; bit 7 resolved crossover
// - status bits 12 and 11 report transmit and receive flow control
// - status 10 reports 100 Mbps, bit 9 reports full duplex
// - status 6 shows negotiation done, bit 5 shows link good
// - status bits 4:0 show partner abilities; reset to zero
`timescale 1ns/1ps
module port2_phy_ctrl_status_regs
   import port2_phy_pkg::*;
(
   // clock, reset, enable
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   // host register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [1:0] reg_be,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   // standard register alias port
   input wire logic basic_ctrl_wr,
   input wire logic [15:0] basic_ctrl_wdata,
   input wire logic advertise_wr,
   input wire logic [15:0] advertise_wdata,
   output logic [15:0] port2_basic_control_alias,
   output logic [15:0] port2_basic_status_alias,
   output logic [15:0] port2_advertise_alias,
   output logic [15:0] port2_partner_ability_alias,
   output logic [15:0] port2_phy_special_alias,
   // live state from the phy
   input wire logic phy_link_up,
   input wire logic phy_an_done,
   input wire logic phy_an_failed,
   input wire logic phy_an_speed100,
   input wire logic phy_an_full,
   input wire logic phy_pol_reversed,
   input wire logic phy_mdix_state,
   input wire logic phy_tx_fc_active,
   input wire logic phy_rx_fc_active,
   input wire logic [ADV_W-1:0] phy_partner_abil,
   // controls to the phy
   output logic phy_tx_disable,
   output logic phy_an_restart,
   output logic phy_power_down,
   output logic phy_far_loopback,
   output logic phy_an_enable,
   output logic [ADV_W-1:0] phy_advertise,
   output logic crossover_algorithm_select,
   output logic phy_auto_mdix_en,
   output logic phy_force_mdix,
   output logic phy_speed100,
   output logic phy_full_duplex
);

   logic [15:0] ctl_q;
   logic [15:0] ctl_d;
   logic algo_q;
   logic algo_d;
   logic restart_q;
   logic [14:0] live_q;
   logic [ADV_W-1:0] partner_q;
   logic speed100;
   logic full_duplex;
   logic [15:0] status_word;
   logic [15:0] rdata_q;
   logic rvalid_q;
   logic host_ctl_wr;
   logic host_sts_wr;

   assign host_ctl_wr = reg_wr && (reg_addr == PORT2_PHY_CONTROL_OFS);
   assign host_sts_wr = reg_wr && (reg_addr == PORT2_PHY_STATUS_OFS);

   // ---------------------------------------------------------------
   // control register next value
   // ---------------------------------------------------------------
   // alias writes first, host last: a same-cycle collision goes to
   // the host. restart clears itself, but any fresh set wins.
   always_comb begin
      ctl_d = ctl_q;
      if (ctl_q[CTL_AN_RESTART]) begin
         ctl_d[CTL_AN_RESTART] = 1'b0;
      end
      if (basic_ctrl_wr) begin
         ctl_d[CTL_FAR_LOOP] = basic_ctrl_wdata[BC_FAR_LOOP];
         ctl_d[CTL_SPEED] = basic_ctrl_wdata[BC_SPEED];
         ctl_d[CTL_AN_EN] = basic_ctrl_wdata[BC_AN_EN];
         ctl_d[CTL_POWER_DOWN] = basic_ctrl_wdata[BC_POWER_DOWN];
         ctl_d[CTL_DUPLEX] = basic_ctrl_wdata[BC_DUPLEX];
         ctl_d[CTL_FORCE_MDIX] = basic_ctrl_wdata[BC_FORCE_MDIX];
         ctl_d[CTL_MDIX_DIS] = basic_ctrl_wdata[BC_MDIX_DIS];
         ctl_d[CTL_RSVD12] = basic_ctrl_wdata[BC_RSVD];
         ctl_d[CTL_TX_DIS] = basic_ctrl_wdata[BC_TX_DIS];
         if (basic_ctrl_wdata[BC_AN_RESTART]) begin
            ctl_d[CTL_AN_RESTART] = 1'b1;
         end
      end
      if (advertise_wr) begin
         ctl_d[CTL_ADV_LSB+ADV_W-1] = advertise_wdata[AB_PAUSE];
         ctl_d[CTL_ADV_LSB +: ADV_W-1] =
            advertise_wdata[AB_TECH_LSB +: ADV_W-1];
      end
      if (host_ctl_wr && reg_be[0]) begin
         ctl_d[7:0] = reg_wdata[7:0];
      end
      if (host_ctl_wr && reg_be[1]) begin
         ctl_d[15:14] = reg_wdata[15:14];
         ctl_d[12:8] = reg_wdata[12:8];
         if (reg_wdata[CTL_AN_RESTART]) begin
            ctl_d[CTL_AN_RESTART] = 1'b1;
         end
      end
   end

   always_comb begin
      algo_d = algo_q;
      if (basic_ctrl_wr) begin
         algo_d = basic_ctrl_wdata[BC_ALGO];
      end
      if (host_sts_wr && reg_be[1]) begin
         algo_d = reg_wdata[STS_ALGO];
      end
   end

   // ---------------------------------------------------------------
   // control state
   // ---------------------------------------------------------------
   // power down only gates the phy; the register file keeps running
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ctl_q <= PORT2_PHY_CONTROL_RST;
         algo_q <= STS_ALGO_RST;
      end else if (ce) begin
         ctl_q <= ctl_d;
         algo_q <= algo_d;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         restart_q <= 1'b0;
      end else if (ce) begin
         restart_q <= ctl_q[CTL_AN_RESTART];
      end
   end

   // ---------------------------------------------------------------
   // live status capture
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         live_q <= '0;
         partner_q <= PARTNER_RST;
      end else if (ce) begin
         live_q <= '0;
         live_q[STS_POL_REV] <= phy_pol_reversed;
         live_q[STS_TX_FC] <= phy_tx_fc_active;
         live_q[STS_RX_FC] <= phy_rx_fc_active;
         live_q[STS_MDIX] <= phy_mdix_state;
         live_q[STS_AN_DONE] <= phy_an_done;
         live_q[STS_LINK] <= phy_link_up;
         partner_q <= phy_partner_abil;
      end
   end

   phy_mode_resolve u_resolve (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ce(ce),
      .an_en(ctl_q[CTL_AN_EN]),
      .force_speed100(ctl_q[CTL_SPEED]),
      .force_full(ctl_q[CTL_DUPLEX]),
      .mdix_dis(ctl_q[CTL_MDIX_DIS]),
      .mdix_force_req(ctl_q[CTL_FORCE_MDIX]),
      .an_done(phy_an_done),
      .an_failed(phy_an_failed),
      .an_speed100(phy_an_speed100),
      .an_full(phy_an_full),
      .speed100_q(speed100),
      .full_duplex_q(full_duplex),
      .auto_mdix_en_q(phy_auto_mdix_en),
      .force_mdix_q(phy_force_mdix)
   );

   always_comb begin
      status_word = {1'b0, live_q};
      status_word[STS_ALGO] = algo_q;
      status_word[STS_SPEED] = speed100;
      status_word[STS_DUPLEX] = full_duplex;
      status_word[STS_PARTNER_LSB +: ADV_W] = partner_q;
   end

   // ---------------------------------------------------------------
   // host read port
   // ---------------------------------------------------------------
   // unmapped reads answer zero so software sees a clean word
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rdata_q <= RDATA_NONE;
         rvalid_q <= 1'b0;
      end else if (ce) begin
         rvalid_q <= reg_rd;
         if (reg_rd && reg_addr == PORT2_PHY_CONTROL_OFS) begin
            rdata_q <= ctl_q;
         end else if (reg_rd && reg_addr == PORT2_PHY_STATUS_OFS) begin
            rdata_q <= status_word;
         end else if (reg_rd) begin
            rdata_q <= RDATA_NONE;
         end
      end
   end

   // ---------------------------------------------------------------
   // standard register aliases
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         port2_basic_control_alias <= '0;
         port2_basic_status_alias <= '0;
         port2_advertise_alias <= '0;
         port2_partner_ability_alias <= '0;
         port2_phy_special_alias <= '0;
      end else if (ce) begin
         port2_basic_control_alias <= '0;
         port2_basic_status_alias <= '0;
         port2_advertise_alias <= '0;
         port2_partner_ability_alias <= '0;
         port2_phy_special_alias <= '0;
         port2_basic_control_alias[BC_FAR_LOOP] <= ctl_d[CTL_FAR_LOOP];
         port2_basic_control_alias[BC_SPEED] <= ctl_d[CTL_SPEED];
         port2_basic_control_alias[BC_AN_EN] <= ctl_d[CTL_AN_EN];
         port2_basic_control_alias[BC_POWER_DOWN] <=
            ctl_d[CTL_POWER_DOWN];
         port2_basic_control_alias[BC_AN_RESTART] <=
            ctl_d[CTL_AN_RESTART];
         port2_basic_control_alias[BC_DUPLEX] <= ctl_d[CTL_DUPLEX];
         port2_basic_control_alias[BC_ALGO] <= algo_d;
         port2_basic_control_alias[BC_FORCE_MDIX] <=
            ctl_d[CTL_FORCE_MDIX];
         port2_basic_control_alias[BC_MDIX_DIS] <= ctl_d[CTL_MDIX_DIS];
         port2_basic_control_alias[BC_RSVD] <= ctl_d[CTL_RSVD12];
         port2_basic_control_alias[BC_TX_DIS] <= ctl_d[CTL_TX_DIS];
         port2_basic_status_alias[BS_AN_DONE] <= phy_an_done;
         port2_basic_status_alias[BS_LINK] <= phy_link_up;
         port2_advertise_alias[AB_PAUSE] <= ctl_d[CTL_ADV_LSB+ADV_W-1];
         port2_advertise_alias[AB_TECH_LSB +: ADV_W-1] <=
            ctl_d[CTL_ADV_LSB +: ADV_W-1];
         port2_partner_ability_alias[AB_PAUSE] <=
            phy_partner_abil[ADV_W-1];
         port2_partner_ability_alias[AB_TECH_LSB +: ADV_W-1] <=
            phy_partner_abil[ADV_W-2:0];
         port2_phy_special_alias[SP_POL_REV] <= phy_pol_reversed;
         port2_phy_special_alias[SP_MDIX] <= phy_mdix_state;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign reg_rdata = rdata_q;
   assign reg_rvalid = rvalid_q;
   assign phy_tx_disable = ctl_q[CTL_TX_DIS];
   assign phy_an_restart = restart_q;
   assign phy_power_down = ctl_q[CTL_POWER_DOWN];
   assign phy_far_loopback = ctl_q[CTL_FAR_LOOP];
   assign phy_an_enable = ctl_q[CTL_AN_EN];
   assign phy_advertise = ctl_q[CTL_ADV_LSB +: ADV_W];
   assign crossover_algorithm_select = algo_q;
   assign phy_speed100 = speed100;
   assign phy_full_duplex = full_duplex;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence restart_written;
      ce && host_ctl_wr && reg_be[1] && reg_wdata[CTL_AN_RESTART];
   endsequence
   sequence restart_issued;
      ce && ctl_q[CTL_AN_RESTART] ##1 phy_an_restart;
   endsequence
   chk_tx_disable: assert property (
      ce && host_ctl_wr && reg_be[1] && !basic_ctrl_wr
         |=> phy_tx_disable == $past(reg_wdata[CTL_TX_DIS]))
      else $error("transmit disable does not follow write");
   chk_restart_seq: assert property (
      restart_written ##1 (ce && !basic_ctrl_wr && !reg_wr)
         |-> restart_issued ##0 !ctl_q[CTL_AN_RESTART])
      else $error("restart not pulsed or not self-cleared");
   chk_power_keep: assert property (
      ce && phy_power_down && !reg_wr && !basic_ctrl_wr && !advertise_wr
         && !ctl_q[CTL_AN_RESTART] |=> $stable(ctl_q))
      else $error("registers changed while powered down");
   chk_far_loop: assert property (
      ce && host_ctl_wr && reg_be[1]
         |=> phy_far_loopback == $past(reg_wdata[CTL_FAR_LOOP]))
      else $error("far-end loopback does not follow write");
   chk_forced_speed: assert property (
      ce && !phy_an_enable ##1 ce && !phy_an_enable
         |=> phy_speed100 == $past(ctl_q[CTL_SPEED]))
      else $error("forced speed not on phy");
   chk_advertise_wr: assert property (
      ce && host_ctl_wr && reg_be[0]
         |=> phy_advertise == $past(reg_wdata[ADV_W-1:0]))
      else $error("advertised abilities do not follow write");
   chk_algo_wr: assert property (
      ce && host_sts_wr && reg_be[1]
         |=> crossover_algorithm_select == $past(reg_wdata[STS_ALGO]))
      else $error("crossover algorithm bit not written");
   chk_status_read: assert property (
      ce && reg_rd && reg_addr == PORT2_PHY_STATUS_OFS
         |=> reg_rvalid && reg_rdata[STS_LINK] == $past(live_q[STS_LINK]))
      else $error("link status read back wrong");
   chk_partner_read: assert property (
      ce && reg_rd && reg_addr == PORT2_PHY_STATUS_OFS
         |=> reg_rdata[ADV_W-1:0] == $past(partner_q))
      else $error("partner abilities read back wrong");
   chk_alias_ctrl: assert property (
      ce && basic_ctrl_wr && !reg_wr
         |=> phy_tx_disable == port2_basic_control_alias[BC_TX_DIS]
            && phy_an_enable == port2_basic_control_alias[BC_AN_EN])
      else $error("control alias disagrees with control register");

endmodule : port2_phy_ctrl_status_regs

// ===== tb/link_partner_model.sv
`timescale 1ns/1ps
module link_partner_model #(
   parameter int AN_CYC = 8
) (
   // clock
   input wire logic clk_sys,
   // port controls
   input wire logic phy_an_restart,
   input wire logic phy_power_down,
   input wire logic [4:0] phy_advertise,
   // cable setup from the bench
   input wire logic [4:0] cab_abil,
   input wire logic cab_pol,
   input wire logic cab_x,
   // live state back to the port
   output logic phy_link_up,
   output logic phy_an_done,
   output logic phy_an_failed,
   output logic phy_an_speed100,
   output logic phy_an_full,
   output logic phy_pol_reversed,
   output logic phy_mdix_state,
   output logic phy_tx_fc_active,
   output logic phy_rx_fc_active,
   output logic [4:0] phy_partner_abil
);
   logic [3:0] common;
   logic full;
   logic fc;
   int cnt = -1;
   assign common = phy_advertise[3:0] & cab_abil[3:0];
   assign full = common[3] | (!common[2] & common[1]);
   assign fc = full & phy_advertise[4] & cab_abil[4];
   initial begin
      {phy_link_up, phy_an_done, phy_an_failed, phy_an_speed100} = '0;
      {phy_an_full, phy_tx_fc_active, phy_rx_fc_active} = '0;
      {phy_pol_reversed, phy_mdix_state, phy_partner_abil} = '0;
   end
   // changes land on the falling edge, clear of the port's sampling edge
   always @(negedge clk_sys) begin
      phy_pol_reversed <= cab_pol;
      phy_mdix_state <= cab_x;
      if (phy_an_restart || phy_power_down) begin
         cnt <= AN_CYC;
         phy_link_up <= 1'b0;
         phy_an_done <= 1'b0;
         phy_an_failed <= 1'b0;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end else if (cnt == 0) begin
         cnt <= -1;
         phy_an_done <= (common != 4'h0);
         phy_an_failed <= (common == 4'h0);
         phy_link_up <= (common != 4'h0);
         phy_an_speed100 <= common[3] | common[2];
         phy_an_full <= full;
         phy_tx_fc_active <= fc;
         phy_rx_fc_active <= fc;
         phy_partner_abil <= cab_abil;
      end
   end
endmodule : link_partner_model

// ===== tb/test_port2_phy_ctrl_status_regs.sv
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; \
   $display("ERROR %0t got %h exp %h", $time, a, e); end end
module test_port2_phy_ctrl_status_regs
   import port2_phy_pkg::*;
   ;
   // ---------------------------------------------------------------
   // stimulus and wiring
   // ---------------------------------------------------------------
   logic clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b1;
   logic [ADDR_W-1:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0, reg_rd = 1'b0;
   logic [1:0] reg_be = 2'h0;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata;
   logic reg_rvalid, basic_ctrl_wr = 1'b0, advertise_wr = 1'b0;
   logic [15:0] basic_ctrl_wdata = 16'h0000, advertise_wdata = 16'h0000;
   logic [15:0] port2_basic_control_alias, port2_basic_status_alias;
   logic [15:0] port2_advertise_alias, port2_partner_ability_alias;
   logic [15:0] port2_phy_special_alias;
   logic phy_link_up, phy_an_done, phy_an_failed, phy_an_speed100;
   logic phy_an_full, phy_pol_reversed, phy_mdix_state;
   logic phy_tx_fc_active, phy_rx_fc_active;
   logic [4:0] phy_partner_abil, phy_advertise, cab_abil = 5'h00;
   logic cab_pol = 1'b0, cab_x = 1'b0;
   logic phy_tx_disable, phy_an_restart, phy_power_down, phy_far_loopback;
   logic phy_an_enable, crossover_algorithm_select, phy_auto_mdix_en;
   logic phy_force_mdix, phy_speed100, phy_full_duplex;
   int err_total = 0, tests_run = 0, cyc = 0;

   port2_phy_ctrl_status_regs port2_phy_ctrl_status_regs_inst (
      .clk_sys, .rst_n, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_be,
      .reg_wdata, .reg_rdata, .reg_rvalid, .basic_ctrl_wr,
      .basic_ctrl_wdata, .advertise_wr, .advertise_wdata,
      .port2_basic_control_alias, .port2_basic_status_alias,
      .port2_advertise_alias, .port2_partner_ability_alias,
      .port2_phy_special_alias, .phy_link_up, .phy_an_done,
      .phy_an_failed, .phy_an_speed100, .phy_an_full, .phy_pol_reversed,
      .phy_mdix_state, .phy_tx_fc_active, .phy_rx_fc_active,
      .phy_partner_abil, .phy_tx_disable, .phy_an_restart,
      .phy_power_down, .phy_far_loopback, .phy_an_enable, .phy_advertise,
      .crossover_algorithm_select, .phy_auto_mdix_en, .phy_force_mdix,
      .phy_speed100, .phy_full_duplex);

   link_partner_model #(.AN_CYC(8)) link_partner_model_inst (
      .clk_sys, .phy_an_restart, .phy_power_down, .phy_advertise,
      .cab_abil, .cab_pol, .cab_x, .phy_link_up, .phy_an_done,
      .phy_an_failed, .phy_an_speed100, .phy_an_full, .phy_pol_reversed,
      .phy_mdix_state, .phy_tx_fc_active, .phy_rx_fc_active,
      .phy_partner_abil);

   always #12.5 clk_sys = ~clk_sys;

   // ---------------------------------------------------------------
   // bus tasks
   // ---------------------------------------------------------------
   // returns a cycle and a half after the write lands, so registered outputs settle
   task automatic wr(input logic [7:0] a, input logic [1:0] be,
                     input logic [15:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_be = be;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
      @(negedge clk_sys);
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [15:0] e);
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      `CHK(reg_rvalid, 1'b1)
      `CHK(reg_rdata, e)
   endtask : rchk

   task automatic report_and_stop;
      if (err_total == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      rchk(PORT2_PHY_CONTROL_OFS, 16'h00FF);
      rchk(PORT2_PHY_STATUS_OFS, 16'h8000);
      `CHK({phy_an_enable, phy_advertise, phy_speed100}, 7'h7E)
      `CHK(crossover_algorithm_select, 1'b1)
   endtask : t_reset

   task automatic t_restart;
      wr(PORT2_PHY_CONTROL_OFS, 2'h3, 16'h20FF);
      `CHK(phy_an_restart, 1'b1)
      @(negedge clk_sys);
      `CHK(phy_an_restart, 1'b0)
      rchk(PORT2_PHY_CONTROL_OFS, 16'h00FF);
   endtask : t_restart

   task automatic t_table;
      logic [15:0] d[6] = '{16'h4000, 16'h0815, 16'h0100, 16'h0080,
                            16'h0600, 16'h0200};
      logic [5:0] e[6] = '{6'h22, 6'h12, 6'h0A, 6'h06, 6'h01, 6'h02};
      logic [5:0] pins;
      for (int i = 0; i < 6; i++) begin
         wr(PORT2_PHY_CONTROL_OFS, 2'h3, d[i]);
         pins = {phy_tx_disable, phy_power_down, phy_far_loopback,
                 phy_an_enable, phy_auto_mdix_en, phy_force_mdix};
         `CHK(pins, e[i])
         `CHK(phy_advertise, d[i][4:0])
         rchk(PORT2_PHY_CONTROL_OFS, d[i]);
      end
   endtask : t_table

   task automatic t_forced;
      for (int i = 0; i < 4; i++) begin
         wr(PORT2_PHY_CONTROL_OFS, 2'h3, 16'h001F | (16'(i) << 5));
         `CHK({phy_speed100, phy_full_duplex}, i[1:0])
         rchk(PORT2_PHY_STATUS_OFS, {5'h10, i[1:0], 9'h000});
      end
   endtask : t_forced

   task automatic t_negotiate;
      // last case leaves duplex set on purpose to see it used on failure
      logic [15:0] c[3] = '{16'h209F, 16'h2081, 16'h20A1};
      logic [6:0] cab[3] = '{7'h7F, 7'h1F, 7'h10};
      logic [15:0] s[3] = '{16'hBEFF, 16'h807F, 16'h8210};
      logic [15:0] ex;
      for (int i = 0; i < 3; i++) begin
         {cab_pol, cab_x, cab_abil} = cab[i];
         wr(PORT2_PHY_CONTROL_OFS, 2'h3, c[i]);
         repeat (16) @(negedge clk_sys);
         `CHK({phy_speed100, phy_full_duplex}, s[i][10:9])
         rchk(PORT2_PHY_STATUS_OFS, s[i]);
         ex = {5'h00, s[i][4], 1'b0, s[i][3:0], 5'h00};
         `CHK(port2_partner_ability_alias, ex)
         ex = {10'h000, s[i][6], 2'h0, s[i][5], 2'h0};
         `CHK(port2_basic_status_alias, ex)
         ex = {10'h000, s[i][13], s[i][7], 4'h0};
         `CHK(port2_phy_special_alias, ex)
      end
   endtask : t_negotiate

   task automatic t_alias;
      wr(PORT2_PHY_CONTROL_OFS, 2'h3, 16'h0000);
      basic_ctrl_wdata = 16'h1022;
      basic_ctrl_wr = 1'b1;
      @(negedge clk_sys);
      basic_ctrl_wr = 1'b0;
      `CHK(phy_tx_disable, 1'b1)
      `CHK(port2_basic_control_alias, 16'h1022)
      advertise_wdata = 16'h0420;
      advertise_wr = 1'b1;
      @(negedge clk_sys);
      advertise_wr = 1'b0;
      `CHK(port2_advertise_alias, 16'h0420)
      rchk(PORT2_PHY_CONTROL_OFS, 16'h4091);
   endtask : t_alias

   task automatic t_status;
      wr(PORT2_PHY_STATUS_OFS, 2'h1, 16'h0000);
      `CHK(crossover_algorithm_select, 1'b1)
      wr(PORT2_PHY_STATUS_OFS, 2'h3, 16'h0000);
      `CHK(crossover_algorithm_select, 1'b0)
      `CHK(port2_basic_control_alias[5], 1'b0)
      ce = 1'b0;
      wr(PORT2_PHY_STATUS_OFS, 2'h3, 16'h8000);
      ce = 1'b1;
      `CHK(crossover_algorithm_select, 1'b0)
      wr(PORT2_PHY_STATUS_OFS, 2'h2, 16'h8000);
      `CHK(crossover_algorithm_select, 1'b1)
      rchk(8'h9A, 16'h0000);
   endtask : t_status

   // ---------------------------------------------------------------
   // sequence and watchdog
   // ---------------------------------------------------------------
   // the whole run is about 150 cycles; the ceiling only cuts hangs
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         report_and_stop();
      end
   end

   initial begin
      repeat (3) @(negedge clk_sys);
      rst_n = 1'b1;
      t_reset();
      t_restart();
      t_table();
      t_forced();
      t_negotiate();
      t_alias();
      t_status();
      report_and_stop();
   end
endmodule : test_port2_phy_ctrl_status_regs
